// ### rtl/dual_adc_serial_readout.sv
`timescale 1ns/1ps

module dual_adc_serial_readout (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // converter core samples
    input  wire logic [13:0] chan_a_sample_in,
    input  wire logic [13:0] chan_b_sample_in,
    // link pins
    input  wire logic        conversion_strobe_in,
    input  wire logic        serial_clock_in,
    output logic             miso_out,
    output logic             miso_oe_out,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);

    localparam int unsigned RW = adc_pkg::RESULT_W;

    // ========================================================================
    // reset release
    logic rst_meta_r;
    logic rst_sync_r;

    // release through two flops so every flop leaves reset on the same edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ========================================================================
    // pin synchronisers and edge detection
    logic [1:0] pins_sync;
    logic       sclk_q_r;
    logic       strobe_q_r;

    sync_stage #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_sync_r),
        .d_in     ({serial_clock_in, conversion_strobe_in}),
        .q_out    (pins_sync)
    );

    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sclk_q_r   <= 1'b0;
            strobe_q_r <= 1'b0;
        end else begin
            sclk_q_r   <= pins_sync[1];
            strobe_q_r <= pins_sync[0];
        end
    end

    logic ctl_enable;
    logic ctl_pattern;
    logic strobe_rise;
    logic sclk_fall;

    // the strobe acts on its rising edge only, its level does not frame anything
    assign strobe_rise = pins_sync[0] & ~strobe_q_r & ctl_enable;   // RULE7
    assign sclk_fall   = ~pins_sync[1] & sclk_q_r;

    // ========================================================================
    // registers and state
    logic [1:0]        ctl_r;
    logic [2*RW-1:0]   pattern_r;
    logic [RW-1:0]     hold_a_r;
    logic [RW-1:0]     hold_b_r;
    logic [RW-1:0]     out_a_r;
    logic [RW-1:0]     out_b_r;
    logic [5:0]        cnt_r;
    logic              active_r;
    logic              cut_r;
    logic              fast_r;
    logic [7:0]        frames_r;
    logic [adc_pkg::GAP_W-1:0] gap_r;
    logic              ack_r;

    assign ctl_enable  = ctl_r[adc_pkg::CTL_ENABLE_BIT];
    assign ctl_pattern = ctl_r[adc_pkg::CTL_PATTERN_BIT];

    // ========================================================================
    // avalon decode: one wait state, answer on the second cycle
    logic        req;
    logic        wr_take;
    logic        sel_ctl;
    logic        sel_pat;
    logic        sel_st;
    logic [31:0] wmask;
    logic [31:0] wdata_ctl;
    logic [31:0] wdata_pat;
    logic [31:0] pat_word;
    logic [31:0] rd_mux;
    logic        cut_clr;
    logic        fast_clr;

    assign req     = avs_read_in | avs_write_in;
    assign wr_take = avs_write_in & ack_r;
    assign sel_ctl = avs_address_in == adc_pkg::REG_CONTROL;
    assign sel_pat = avs_address_in == adc_pkg::REG_PATTERN;
    assign sel_st  = avs_address_in == adc_pkg::REG_STATUS;
    assign wmask   = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign pat_word  = {2'h0, pattern_r[2*RW-1:RW], 2'h0, pattern_r[RW-1:0]};
    assign wdata_ctl = ({30'h0, ctl_r} & ~wmask) | (avs_writedata_in & wmask);
    assign wdata_pat = (pat_word & ~wmask) | (avs_writedata_in & wmask);
    assign cut_clr   = wr_take & sel_st & wmask[adc_pkg::ST_CUT_BIT]
                       & avs_writedata_in[adc_pkg::ST_CUT_BIT];
    assign fast_clr  = wr_take & sel_st & wmask[adc_pkg::ST_FAST_BIT]
                       & avs_writedata_in[adc_pkg::ST_FAST_BIT];
    assign avs_waitrequest_out = req & ~ack_r;

    always_comb begin
        case (avs_address_in)
            adc_pkg::REG_CONTROL: rd_mux = {30'h0, ctl_r};
            adc_pkg::REG_PATTERN: rd_mux = pat_word;
            adc_pkg::REG_RESULT:  rd_mux = {2'h0, hold_b_r, 2'h0, hold_a_r};
            adc_pkg::REG_STATUS:  rd_mux = {16'h0, frames_r, 4'h0, fast_r, cut_r,
                                            miso_oe_out, active_r};
            default:              rd_mux = 32'h0;   // unmapped words read zero
        endcase
    end

    // bus handshake and software registers
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ack_r            <= 1'b0;
            avs_readdata_out <= 32'h0;
            ctl_r            <= adc_pkg::CTL_RESET;
            pattern_r        <= '0;
        end else begin
            ack_r <= req & ~ack_r;
            if (avs_read_in & ~ack_r)
                avs_readdata_out <= rd_mux;
            if (wr_take & sel_ctl)
                ctl_r <= wdata_ctl[1:0];
            if (wr_take & sel_pat)
                pattern_r <= {wdata_pat[adc_pkg::CHB_LSB +: RW], wdata_pat[RW-1:0]};
        end
    end

    // ========================================================================
    // conversion capture and one-sample pipeline
    logic [RW-1:0] src_a;
    logic [RW-1:0] src_b;

    assign src_a = ctl_pattern ? pattern_r[RW-1:0] : chan_a_sample_in;
    assign src_b = ctl_pattern ? pattern_r[2*RW-1:RW] : chan_b_sample_in;

    // both holds load on the same edge; the previous pair moves to the shifter
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            hold_a_r <= '0;
            hold_b_r <= '0;
            out_a_r  <= '0;
            out_b_r  <= '0;
        end else if (strobe_rise) begin
            hold_a_r <= src_a;      // RULE1
            hold_b_r <= src_b;      // RULE1
            out_a_r  <= hold_a_r;   // RULE2
            out_b_r  <= hold_b_r;   // RULE2
        end
    end

    // ========================================================================
    // frame sequencing on serial clock falling edges
    logic in_a;
    logic in_b;
    logic bit_nxt;
    logic [5:0] idx_a;
    logic [5:0] idx_b;

    assign in_a  = active_r & (cnt_r >= adc_pkg::A_FIRST) & (cnt_r <= adc_pkg::A_LAST);
    assign in_b  = active_r & (cnt_r >= adc_pkg::B_FIRST) & (cnt_r <= adc_pkg::B_LAST);
    assign idx_a = adc_pkg::A_LAST - cnt_r;
    assign idx_b = adc_pkg::B_LAST - cnt_r;
    // msb first; two's complement words go out unchanged
    assign bit_nxt = in_a ? out_a_r[idx_a[3:0]] : (in_b ? out_b_r[idx_b[3:0]] : 1'b0); // RULE3

    // a new strobe restarts the frame; an unfinished one is flagged as cut
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cnt_r    <= '0;
            active_r <= 1'b0;
            frames_r <= '0;
        end else if (strobe_rise) begin
            cnt_r    <= '0;
            active_r <= 1'b1;
        end else if (active_r & sclk_fall) begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == adc_pkg::FRAME_END - 6'h01) begin
                active_r <= 1'b0;       // RULE5
                frames_r <= frames_r + 8'h01;
            end
        end
    end

    // data pin is registered; it stays released outside the two word slots
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0;
        end else begin
            miso_out    <= bit_nxt;
            miso_oe_out <= in_a | in_b;     // RULE4
        end
    end

    // ========================================================================
    // sticky diagnostics: set wins over a clear in the same cycle
    localparam int unsigned GW = adc_pkg::GAP_W;
    // minimum strobe spacing in clocks, cut to the gap counter width
    localparam logic [GW-1:0] MIN_GAP = GW'(adc_pkg::STROBE_MIN_CYC);
    localparam logic [GW-1:0] GAP_ONE = GW'(1);

    logic cut_set;
    logic fast_set;

    // a short frame leaves the line held until the master clocks it out or a new strobe restarts the frame
    assign cut_set  = strobe_rise & active_r;                                   // RULE6
    assign fast_set = strobe_rise & (gap_r < MIN_GAP);                          // RULE8

    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            cut_r  <= 1'b0;
            fast_r <= 1'b0;
            gap_r  <= '1;
        end else begin
            cut_r  <= cut_set | (cut_r & ~cut_clr);
            fast_r <= fast_set | (fast_r & ~fast_clr);
            if (strobe_rise)
                gap_r <= '0;
            else if (gap_r != '1)
                gap_r <= gap_r + GAP_ONE;
        end
    end

endmodule : dual_adc_serial_readout

// ### pkg/adc_pkg.sv
// What this block and the devices on its link must do
// RULE1 - strobe rise captures both channels together
// RULE2 - results leave one frame after capture
// RULE3 - two 14-bit two's complement words per frame
// RULE4 - line released two cycles around each word
// RULE5 - master gives 34 serial clocks per frame
// RULE6 - master clocks on until line is released
// RULE7 - strobe is a trigger, not a select
// RULE8 - strobe rate at most about 1.5 MHz
// RULE9 - master disables other bus devices meanwhile
// RULE10 - serial rom only drives in that mode
// RULE11 - one driver on shared input line
// RULE12 - master extracts words by bit position
package adc_pkg;

    // ========================================================================
    // data and frame shape
    localparam int unsigned RESULT_W    = 14;
    localparam int unsigned FRAME_LEN   = 34;
    localparam int unsigned CNT_W       = 6;
    localparam logic [5:0]  A_FIRST     = 6'h02;
    localparam logic [5:0]  A_LAST      = 6'h0F;
    localparam logic [5:0]  B_FIRST     = 6'h12;
    localparam logic [5:0]  B_LAST      = 6'h1F;
    localparam logic [5:0]  FRAME_END   = 6'h22;

    // ========================================================================
    // timing
    localparam int unsigned CLK_KHZ         = 10000;
    localparam int unsigned STROBE_MAX_KHZ  = 1500;
    localparam int unsigned STROBE_MIN_CYC  = CLK_KHZ / STROBE_MAX_KHZ;
    localparam int unsigned GAP_W           = 4;

    // ========================================================================
    // register word indices on the avalon slave
    localparam logic [2:0] REG_CONTROL  = 3'h0;
    localparam logic [2:0] REG_PATTERN  = 3'h1;
    localparam logic [2:0] REG_RESULT   = 3'h2;
    localparam logic [2:0] REG_STATUS   = 3'h3;

    // control fields
    localparam int unsigned CTL_ENABLE_BIT  = 0;
    localparam int unsigned CTL_PATTERN_BIT = 1;
    localparam logic [1:0]  CTL_RESET       = 2'h1;

    // pattern / result fields: channel a low, channel b high
    localparam int unsigned CHB_LSB         = 16;

    // status fields
    localparam int unsigned ST_ACTIVE_BIT   = 0;
    localparam int unsigned ST_DRIVE_BIT    = 1;
    localparam int unsigned ST_CUT_BIT      = 2;
    localparam int unsigned ST_FAST_BIT     = 3;
    localparam int unsigned ST_COUNT_LSB    = 8;

endpackage : adc_pkg

// ### rtl/sync_stage.sv
`timescale 1ns/1ps

// two-flop synchroniser for levels arriving from outside the clock domain
module sync_stage #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_r;

    // ========================================================================
    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end

endmodule : sync_stage

// ### verification/adc_link_sva.sv
`timescale 1ns/1ps

// ============================================================================
// serial data pin checks, seen from the top ports only
module adc_link_sva (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic conversion_strobe_in,
    input wire logic miso_out,
    input wire logic miso_oe_out
);
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // run lengths of driven and released stretches; saturate so idle never wraps
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_cnt  <= 8'h00;
            high_cnt <= 8'h00;
        end else begin
            low_cnt  <= miso_oe_out ? 8'h00 : ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01);
            high_cnt <= miso_oe_out ? ((high_cnt == 8'hFF) ? high_cnt : high_cnt + 8'h01) : 8'h00;
        end
    end

    // a word is 14 link periods of 8 clocks, one clock of sampling jitter allowed
    property p_word_len;
        $fell(miso_oe_out) |-> (high_cnt >= 8'h6F) && (high_cnt <= 8'h71);
    endproperty
    a_word_len: assert property (p_word_len) else $error("word drive length wrong");

    property p_gap_before;
        $rose(miso_oe_out) |-> low_cnt >= 8'h0F;
    endproperty
    a_gap_before: assert property (p_gap_before) else $error("line driven too soon");

    property p_hold_after;
        $fell(miso_oe_out) |=> !miso_oe_out [*8];
    endproperty
    a_hold_after: assert property (p_hold_after) else $error("line reclaimed early");

    property p_quiet_strobe;
        $rose(conversion_strobe_in) |-> !miso_oe_out [*8];
    endproperty
    a_quiet_strobe: assert property (p_quiet_strobe) else $error("driving at strobe");

    property p_released_low;
        !miso_oe_out |-> !miso_out;
    endproperty
    a_released_low: assert property (p_released_low) else $error("data while released");
endmodule : adc_link_sva

// ### verification/adc_link_master.sv
`timescale 1ns/1ps

// ============================================================================
// logic master on the link: strobes, clocks 34 periods, shifts in both words
module adc_link_master (
    input  wire logic  miso_line_in,
    output logic       strobe_out,
    output logic [0:0] sclk_out,
    output logic [13:0] word_a_out,
    output logic [13:0] word_b_out
);
    // link clock parks high between frames, so it only moves inside a frame
    initial begin
        strobe_out = 1'b0;
        sclk_out   = 1'b1;
        word_a_out = 14'h0000;
        word_b_out = 14'h0000;
    end

    // full frames are tens of microseconds apart, far below the strobe ceiling; a one-clock frame still spaces strobes over a microsecond
    // fewer clocks than a full frame leave it cut, to be restarted by the next strobe
    task automatic run_frame(input int n_clk = 34);
        int i;
        #37 strobe_out = 1'b1; // short trigger pulse, not a frame-long select
        #300 strobe_out = 1'b0;
        for (i = 1; i <= n_clk; i++) begin // n_clk clocks; the default 34 is a full frame so the line is given back
            #400 sclk_out = 1'b0;
            #400 sclk_out = 1'b1;
            if (i >= 2 && i <= 15) word_a_out = {word_a_out[12:0], miso_line_in};
            if (i >= 18 && i <= 31) word_b_out = {word_b_out[12:0], miso_line_in};
        end
    endtask : run_frame
endmodule : adc_link_master

// ### verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    // ========================================================================
    // stimulus and observed signals
    logic        clk_in, rst_b_in, miso_out, miso_oe_out, miso_line, strobe, avs_waitrequest_out;
    logic [13:0] chan_a_sample_in, chan_b_sample_in, word_a, word_b;
    logic [0:0]  sclk;
    logic [2:0]  avs_address_in;
    logic        avs_read_in, avs_write_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q, cur;
    logic [31:0] pair_q[$];
    logic [15:0] lfsr;
    int          mismatches, comparisons, i;

    dual_adc_serial_readout DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .chan_a_sample_in(chan_a_sample_in), .chan_b_sample_in(chan_b_sample_in),
        .conversion_strobe_in(strobe), .serial_clock_in(sclk[0]), .miso_out(miso_out),
        .miso_oe_out(miso_oe_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out));

    adc_link_master u_master (.miso_line_in(miso_line), .strobe_out(strobe), .sclk_out(sclk),
        .word_a_out(word_a), .word_b_out(word_b));

    // other bus devices held disabled; a released line shows the inverse
    assign miso_line = miso_oe_out ? miso_out : ~miso_out;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            mismatches++;
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // one avalon access; held until waitrequest is seen low, bounded wait
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        r = avs_readdata_out;   // read data stand at the edge that ended the wait
        if (n >= 50) begin
            mismatches++;
            finish_test();
        end
    endtask : bus

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ========================================================================
    // main sequence: model queue holds the pair each frame should carry
    initial begin
        {rst_b_in, avs_read_in, avs_write_in, avs_address_in} = '0;
        {avs_writedata_in, chan_a_sample_in, chan_b_sample_in} = '0;
        lfsr = 16'h0019;
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        bus(1'b0, adc_pkg::REG_CONTROL, 32'h0, q);
        check("control", q, 32'h1);
        bus(1'b0, 3'h5, 32'h0, q);
        check("unmapped", q, 32'h0);
        pair_q.push_back(32'h0); // empty pipeline sends zeros first
        for (i = 0; i < 6; i++) begin
            if (i == 3) begin // extreme two's complement codes through the pattern path
                bus(1'b1, adc_pkg::REG_PATTERN, 32'h1FFF_2000, q);
                bus(1'b1, adc_pkg::REG_CONTROL, 32'h3, q);
            end
            lfsr = lfsr_next(lfsr);
            chan_a_sample_in <= lfsr[13:0];
            lfsr = lfsr_next(lfsr);
            chan_b_sample_in <= lfsr[13:0];
            @(posedge clk_in);
            cur = (i >= 3) ? 32'h1FFF_2000 : {2'h0, chan_b_sample_in, 2'h0, chan_a_sample_in};
            pair_q.push_back(cur);
            u_master.run_frame();
            cur = pair_q.pop_front();
            check("word_a", {18'h0, word_a}, {18'h0, cur[13:0]});
            check("word_b", {18'h0, word_b}, {18'h0, cur[29:16]});
            bus(1'b0, adc_pkg::REG_RESULT, 32'h0, q);
            check("result", q, pair_q[0]);
        end
        bus(1'b0, adc_pkg::REG_STATUS, 32'h0, q);
        check("status", {16'h0, q[15:0]}, 32'h0000_0600);
        bus(1'b1, adc_pkg::REG_CONTROL, 32'h0, q); // disabled: strobe must be ignored
        u_master.run_frame();
        bus(1'b0, adc_pkg::REG_STATUS, 32'h0, q);
        check("ignored", {24'h0, q[15:8]}, 32'h6);
        // cut frame: one clock only, then a strobe restarts it and flags the cut
        bus(1'b1, adc_pkg::REG_CONTROL, 32'h3, q);
        u_master.run_frame(1);
        u_master.run_frame();
        check("cut_a", {18'h0, word_a}, {18'h0, cur[13:0]});
        check("cut_b", {18'h0, word_b}, {18'h0, cur[29:16]});
        bus(1'b0, adc_pkg::REG_STATUS, 32'h0, q);
        check("cut_status", {16'h0, q[15:0]}, 32'h0000_0704);
        bus(1'b1, adc_pkg::REG_STATUS, 32'h4, q);
        bus(1'b0, adc_pkg::REG_STATUS, 32'h0, q);
        check("cut_clear", {16'h0, q[15:0]}, 32'h0000_0700);
        finish_test();
    end
endmodule : tb_top

bind dual_adc_serial_readout adc_link_sva u_sva (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .conversion_strobe_in(conversion_strobe_in), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out));
